/* tb/hsc_bus_ctrl.sv */
// bus controller model for the two-wire command port, bit-banged
// assumes pull-ups on both wires; paced by falling edges of clk
module hsc_bus_ctrl
(
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic stuck,
  output logic stretched
);
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    stuck = 1'b0;
    stretched = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // quarter bit of 7 cycles, plus one cycle in up, keeps the clock near 345 kHz
  task automatic q;
    repeat (7) @(negedge clk);
  endtask : q
  // release is the only way up; a stretching target may hold it low
  task automatic up;
    int n;
    n = 0;
    scl_pull = 1'b0;
    @(negedge clk);
    while (scl !== 1'b1 && n < 5000)
    begin
      stretched = 1'b1;
      @(negedge clk);
      n++;
    end
    if (n >= 5000) stuck = 1'b1;
    q;
  endtask : up
  task automatic start;
    stretched = 1'b0;
    sda_pull = 1'b0;
    q;
    up;
    sda_pull = 1'b1;
    q;
    scl_pull = 1'b1;
    q;
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    q;
    up;
    sda_pull = 1'b0;
    q;
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    q;
    up;
    r = sda;
    q;
    scl_pull = 1'b1;
    q;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  // more low refuses the byte and ends the read early
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask : rbyte
endmodule : hsc_bus_ctrl

/* tb/hsc_command_port_asserts.sv */
// pin and status checks for the command port
// assumes the bench pulls both wires up and keeps both clocks running
module hsc_command_port_asserts
#(
  parameter int unsigned CONV_CYCLES = 200
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] humidity_raw,
  input wire logic [15:0] temperature_raw,
  input wire logic conv_active,
  input wire logic sys_idle,
  input wire logic cal_reload
);
  logic [17:0] conv_cnt;
  logic [15:0] up_cnt;
  logic [11:0] sr_cnt;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst) conv_cnt <= '0;
    else if (conv_active) conv_cnt <= conv_cnt + 18'h1;
    else conv_cnt <= '0;
  end
  // saturates so a long run never wraps back into the power-up window
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst) up_cnt <= '0;
    else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h1;
  end
  // soft reset cycles until idle returns; zero when none is pending
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst) sr_cnt <= '0;
    else if (cal_reload) sr_cnt <= 12'h001;
    else if (sys_idle) sr_cnt <= '0;
    else if (sr_cnt != 12'h000) sr_cnt <= sr_cnt + 12'h001;
  end
  ////////////////////////////////////////////////////////////
  property p_idle_no_stretch;
    @(posedge clk_sys) disable iff (!nrst) sys_idle && $past(sys_idle, 8) |-> !scl_oe;
  endproperty
  a_idle_no_stretch: assert property (p_idle_no_stretch)
    else $error("clock held low in idle");
  property p_idle_after_conv;
    @(posedge clk_sys) disable iff (!nrst) $fell(conv_active) |-> ##[0:3] sys_idle;
  endproperty
  a_idle_after_conv: assert property (p_idle_after_conv)
    else $error("no idle after conversion");
  property p_conv_len;
    @(posedge clk_sys) disable iff (!nrst) $fell(conv_active) |->
      conv_cnt >= 18'(CONV_CYCLES - 1) && conv_cnt <= 18'(CONV_CYCLES + 1);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_cal_once;
    @(posedge clk_sys) disable iff (!nrst) cal_reload |-> !conv_active ##1 !cal_reload;
  endproperty
  a_cal_once: assert property (p_cal_once)
    else $error("reload pulse wrong");
  property p_sr_time;
    @(posedge clk_sys) disable iff (!nrst)
      sr_cnt != 12'h000 |-> sr_cnt <= 12'h8fe && (!sys_idle || sr_cnt >= 12'h8fa);
  endproperty
  a_sr_time: assert property (p_sr_time)
    else $error("soft reset time wrong");
  property p_pu_wait;
    @(posedge clk_sys) disable iff (!nrst) up_cnt < 16'h094c |-> !sys_idle;
  endproperty
  a_pu_wait: assert property (p_pu_wait)
    else $error("idle too early");
  property p_pu_done;
    @(posedge clk_sys) disable iff (!nrst) up_cnt == 16'h0960 |-> sys_idle;
  endproperty
  a_pu_done: assert property (p_pu_done)
    else $error("idle too late");
  property p_sda_low_phase;
    @(posedge clk_link) disable iff (!nrst) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase)
    else $error("data moved while clock high");
  property p_stretch_conv;
    @(posedge clk_link) disable iff (!nrst) $rose(scl_oe) |-> conv_active;
  endproperty
  a_stretch_conv: assert property (p_stretch_conv)
    else $error("stretch outside conversion");
  c_stretch: cover property (@(posedge clk_link) disable iff (!nrst) $rose(scl_oe));
  c_reload: cover property (@(posedge clk_sys) disable iff (!nrst) cal_reload);
  c_conv: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(conv_active));
endmodule : hsc_command_port_asserts

bind hsc_command_port hsc_command_port_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk
(
  .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .humidity_raw(humidity_raw), .temperature_raw(temperature_raw),
  .conv_active(conv_active), .sys_idle(sys_idle), .cal_reload(cal_reload)
);

/* tb/hsc_command_port_tb.sv */
// self-checking bench for the humidity sensor command port
// assumes the bus controller model and the bound checker are compiled first
module hsc_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 1000;
  typedef struct {
    logic [15:0] cmd;
    logic [15:0] hum;
    logic [15:0] tmp;
    logic t_first;
    logic stretch;
  } hsc_row_type;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] humidity_raw = 16'h0;
  logic [15:0] temperature_raw = 16'h0;
  logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
  logic conv_active, sys_idle, cal_reload;
  logic scl_pull, sda_pull, stuck, stretched, ack;
  logic [7:0] d;
  int err_total = 0;
  int n_checks = 0;
  int cal_n = 0;
  hsc_row_type rows [4];
  // 100 ns and 32 ns periods never share a rising edge
  always #50 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;
  assign scl_in = ~(scl_oe | scl_pull);
  assign sda_in = ~(sda_oe | sda_pull);
  always @(negedge clk_sys) if (cal_reload === 1'b1) cal_n++;
  hsc_command_port #(.CONV_CYCLES(CONV)) dut
  (
    .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .humidity_raw(humidity_raw), .temperature_raw(temperature_raw),
    .conv_active(conv_active), .sys_idle(sys_idle), .cal_reload(cal_reload)
  );
  hsc_bus_ctrl ctrl
  (
    .clk(clk_sys), .scl(scl_in), .sda(sda_in), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .stuck(stuck), .stretched(stretched)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] crc_ref(input logic [15:0] w);
    logic [7:0] c;
    c = hsc_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ hsc_pkg::CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc_ref
  task automatic wait_idle;
    int n;
    n = 0;
    while (sys_idle !== 1'b1 && n < 5000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 5000)
    begin
      err_total++;
      end_sim;
    end
  endtask : wait_idle
  // a header expected to be refused (exp zero) ends the transaction at once
  task automatic send(input logic [7:0] hdr, input logic [15:0] cmd, input logic [15:0] exp);
    ctrl.start;
    ctrl.wbyte(hdr, ack);
    chk(16'(ack), exp);
    if (exp == 16'h1)
    begin
      ctrl.wbyte(cmd[15:8], ack);
      chk(16'(ack), 16'h1);
      ctrl.wbyte(cmd[7:0], ack);
      chk(16'(ack), 16'h1);
    end
    ctrl.stop;
  endtask : send
  task automatic readout(input logic [15:0] w0, input logic [15:0] w1, input int n);
    logic [7:0] exp_b [6];
    exp_b = '{w0[15:8], w0[7:0], crc_ref(w0), w1[15:8], w1[7:0], crc_ref(w1)};
    ctrl.start;
    ctrl.wbyte({hsc_pkg::ADDR, 1'b1}, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < n; i++)
    begin
      ctrl.rbyte(i < n - 1, d);
      chk(16'(d), 16'(exp_b[i]));
    end
    if (n < 6)
    begin
      ctrl.rbyte(1'b0, d);
      chk(16'(d), 16'h00ff);
    end
    ctrl.stop;
  endtask : readout
  ////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = '{hsc_pkg::CMD_STRETCH_TEMP, 16'hbeef, 16'h0000, 1'b1, 1'b1};
    rows[1] = '{hsc_pkg::CMD_STRETCH_HUM, 16'h6666, 16'h5a5a, 1'b0, 1'b1};
    rows[2] = '{hsc_pkg::CMD_FREE_TEMP, 16'hffff, 16'h0001, 1'b1, 1'b0};
    rows[3] = '{hsc_pkg::CMD_FREE_HUM, 16'h8000, 16'h7fff, 1'b0, 1'b0};
    repeat (5) @(negedge clk_sys);
    chk(16'({scl_oe, sda_oe, conv_active, sys_idle, cal_reload}), 16'h0);
    // released off the link edges: reset release is not synchronised there
    #3 nrst = 1'b1;
    repeat (2370) @(negedge clk_sys);
    chk(16'(sys_idle), 16'h0);
    wait_idle;
    send(8'h72, 16'h0, 16'h0);
    send({hsc_pkg::ADDR, 1'b0}, 16'h1234, 16'h1);
    chk(16'(sys_idle), 16'h1);
    foreach (rows[i])
    begin
      humidity_raw = rows[i].hum;
      temperature_raw = rows[i].tmp;
      send({hsc_pkg::ADDR, 1'b0}, rows[i].cmd, 16'h1);
      chk(16'(conv_active), 16'h1);
      if (!rows[i].stretch)
      begin
        send({hsc_pkg::ADDR, 1'b1}, 16'h0, 16'h0);
        wait_idle;
      end
      if (rows[i].t_first) readout(rows[i].tmp, rows[i].hum, 6);
      else readout(rows[i].hum, rows[i].tmp, 6);
      chk(16'(stretched), 16'(rows[i].stretch));
      wait_idle;
    end
    readout(rows[3].hum, rows[3].tmp, 2);
    readout(rows[3].hum, rows[3].tmp, 5);
    send({hsc_pkg::ADDR, 1'b0}, hsc_pkg::CMD_SOFT_RESET, 16'h1);
    chk(16'(cal_n), 16'h1);
    wait_idle;
    send({hsc_pkg::ADDR, 1'b1}, 16'h0, 16'h0);
    send({hsc_pkg::ADDR, 1'b0}, hsc_pkg::CMD_FREE_TEMP, 16'h1);
    send({hsc_pkg::ADDR, 1'b0}, hsc_pkg::CMD_SOFT_RESET, 16'h0);
    nrst = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(16'({scl_oe, sda_oe, conv_active, sys_idle, cal_reload}), 16'h0);
    #3 nrst = 1'b1;
    wait_idle;
    send({hsc_pkg::ADDR, 1'b1}, 16'h0, 16'h0);
    chk(16'(cal_n), 16'h1);
    chk(16'(stuck), 16'h0);
    chk(16'({scl_out, sda_out}), 16'h0);
    end_sim;
  end
endmodule : hsc_command_port_tb

/* verilog/hsc_command_port.sv */
// two-wire target command port of a humidity and temperature sensor
// assumes external pull-ups; pins arrive asynchronous, clk_link oversamples them
// clk_sys domain runs power-up, conversion and soft reset timing
module hsc_command_port
#(
  parameter int unsigned CONV_CYCLES = hsc_pkg::CONVERSION_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_link,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] humidity_raw,
  input wire logic [15:0] temperature_raw,
  output logic conv_active,
  output logic sys_idle,
  output logic cal_reload
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: pin synchronisers and bus events

  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic done_s1, done_s2, done_d;
  logic done_tgl;
  logic [15:0] hum_res, tmp_res;

  always_ff @(posedge clk_link or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_d <= 1'b0;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_d <= done_s2;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev, done_ev;

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign done_ev = done_s2 ^ done_d;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: checksums and outgoing byte selection

  hsc_crc_if crc_a ();
  hsc_crc_if crc_b ();

  logic [15:0] first_word, second_word;

  assign crc_a.word = first_word;
  assign crc_b.word = second_word;

  hsc_crc8 u_crc_first
  (
    .clk (clk_link),
    .nrst (nrst),
    .port (crc_a.calc)
  );

  hsc_crc8 u_crc_second
  (
    .clk (clk_link),
    .nrst (nrst),
    .port (crc_b.calc)
  );

  hsc_pkg::hsc_link_state_type lstate;
  logic [2:0] byte_idx;
  logic [2:0] load_idx;
  logic [7:0] load_byte;

  assign load_idx = (lstate == hsc_pkg::LK_MACK) ? 3'(byte_idx + 3'h1) : 3'h0;

  always_comb
  begin
    case (load_idx)
      3'h0: load_byte = first_word[15:8];
      3'h1: load_byte = first_word[7:0];
      3'h2: load_byte = crc_a.crc;
      3'h3: load_byte = second_word[15:8];
      3'h4: load_byte = second_word[7:0];
      default: load_byte = crc_b.crc;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: protocol engine

  hsc_pkg::hsc_link_state_type ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] cmd_hi;
  logic busy, busy_meas, stretch_sel, temp_first, results_avail, mack;
  logic req_tgl, req_reset;
  logic [15:0] cmd_word;
  logic addr_ok;

  assign cmd_word = {cmd_hi, shreg};
  assign addr_ok = (shreg[7:1] == hsc_pkg::ADDR);

  // busy starts high: nothing is acknowledged until power-up ends
  always_ff @(posedge clk_link or negedge nrst)
  begin
    if (!nrst)
    begin
      lstate <= hsc_pkg::LK_IDLE;
      ack_next <= hsc_pkg::LK_IGNORE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      cmd_hi <= 8'h00;
      byte_idx <= 3'h0;
      busy <= 1'b1;
      busy_meas <= 1'b0;
      stretch_sel <= 1'b0;
      temp_first <= 1'b0;
      results_avail <= 1'b0;
      mack <= 1'b0;
      req_tgl <= 1'b0;
      req_reset <= 1'b0;
      first_word <= 16'h0000;
      second_word <= 16'h0000;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      if (done_ev)
      begin
        busy <= 1'b0;
        if (busy_meas)
        begin
          results_avail <= 1'b1;
          first_word <= temp_first ? tmp_res : hum_res;
          second_word <= temp_first ? hum_res : tmp_res;
        end
      end
      if (start_ev)
      begin
        lstate <= hsc_pkg::LK_HEADER;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_ev)
      begin
        lstate <= hsc_pkg::LK_IDLE;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end
      else
      begin
        case (lstate)
          hsc_pkg::LK_HEADER, hsc_pkg::LK_CMD:
          begin
            if (scl_rise && bit_cnt != hsc_pkg::BITS_PER_BYTE)
            begin
              shreg <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == hsc_pkg::BITS_PER_BYTE)
            begin
              if (lstate == hsc_pkg::LK_HEADER)
              begin
                if (!addr_ok)
                  lstate <= hsc_pkg::LK_IGNORE;
                else if (busy)
                begin
                  if (shreg[0] && busy_meas && stretch_sel)
                  begin
                    sda_oe <= 1'b1;
                    ack_next <= hsc_pkg::LK_STRETCH;
                    lstate <= hsc_pkg::LK_ACK;
                  end
                  else
                    lstate <= hsc_pkg::LK_IGNORE;
                end
                else if (shreg[0])
                begin
                  // a read with nothing measured is left unacknowledged
                  if (results_avail)
                  begin
                    sda_oe <= 1'b1;
                    byte_idx <= 3'h0;
                    ack_next <= hsc_pkg::LK_SEND;
                    lstate <= hsc_pkg::LK_ACK;
                  end
                  else
                    lstate <= hsc_pkg::LK_IGNORE;
                end
                else
                begin
                  sda_oe <= 1'b1;
                  byte_idx <= 3'h0;
                  ack_next <= hsc_pkg::LK_CMD;
                  lstate <= hsc_pkg::LK_ACK;
                end
              end
              else
              begin
                sda_oe <= 1'b1;
                lstate <= hsc_pkg::LK_ACK;
                if (byte_idx == 3'h0)
                begin
                  cmd_hi <= shreg;
                  byte_idx <= 3'h1;
                  ack_next <= hsc_pkg::LK_CMD;
                end
                else
                begin
                  ack_next <= hsc_pkg::LK_IGNORE;
                  case (cmd_word)
                    hsc_pkg::CMD_STRETCH_TEMP, hsc_pkg::CMD_STRETCH_HUM,
                    hsc_pkg::CMD_FREE_TEMP, hsc_pkg::CMD_FREE_HUM:
                    begin
                      busy <= 1'b1;
                      busy_meas <= 1'b1;
                      results_avail <= 1'b0;
                      req_reset <= 1'b0;
                      req_tgl <= ~req_tgl;
                      stretch_sel <= (cmd_word == hsc_pkg::CMD_STRETCH_TEMP)
                        || (cmd_word == hsc_pkg::CMD_STRETCH_HUM);
                      temp_first <= (cmd_word == hsc_pkg::CMD_STRETCH_TEMP)
                        || (cmd_word == hsc_pkg::CMD_FREE_TEMP);
                    end
                    hsc_pkg::CMD_SOFT_RESET:
                    begin
                      busy <= 1'b1;
                      busy_meas <= 1'b0;
                      results_avail <= 1'b0;
                      stretch_sel <= 1'b0;
                      temp_first <= 1'b0;
                      req_reset <= 1'b1;
                      req_tgl <= ~req_tgl;
                    end
                    default:
                    begin
                    end
                  endcase
                end
              end
            end
          end
          hsc_pkg::LK_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              lstate <= ack_next;
              if (ack_next == hsc_pkg::LK_SEND)
              begin
                shreg <= load_byte;
                sda_oe <= ~load_byte[7];
              end
              else
                sda_oe <= 1'b0;
              if (ack_next == hsc_pkg::LK_STRETCH)
                scl_oe <= 1'b1;
            end
          end
          hsc_pkg::LK_STRETCH:
          begin
            // data bit is set up one link cycle before the clock is let go
            if (results_avail)
            begin
              shreg <= load_byte;
              sda_oe <= ~load_byte[7];
              byte_idx <= 3'h0;
              if (shreg == load_byte && sda_oe == ~load_byte[7])
              begin
                scl_oe <= 1'b0;
                lstate <= hsc_pkg::LK_SEND;
              end
            end
          end
          hsc_pkg::LK_SEND:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == hsc_pkg::BITS_PER_BYTE - 4'h1)
              begin
                sda_oe <= 1'b0;
                lstate <= hsc_pkg::LK_MACK;
              end
              else
              begin
                bit_cnt <= bit_cnt + 4'h1;
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          hsc_pkg::LK_MACK:
          begin
            if (scl_rise)
              mack <= ~sda_s2;
            if (scl_fall)
            begin
              if (mack && byte_idx != hsc_pkg::LAST_BYTE)
              begin
                byte_idx <= load_idx;
                bit_cnt <= 4'h0;
                shreg <= load_byte;
                sda_oe <= ~load_byte[7];
                lstate <= hsc_pkg::LK_SEND;
              end
              else
                lstate <= hsc_pkg::LK_IGNORE;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: request synchroniser

  logic req_s1, req_s2, req_d;
  logic req_ev;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_d <= 1'b0;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_d <= req_s2;
    end
  end

  assign req_ev = req_s2 ^ req_d;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: power-up, conversion and soft reset sequencing

  hsc_pkg::hsc_sys_state_type sstate;
  logic [hsc_pkg::CNT_W-1:0] cnt;

  // req_reset is steady while a request is pending, so it is read unsynchronised
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sstate <= hsc_pkg::SY_POWER_UP;
      cnt <= '0;
      done_tgl <= 1'b0;
      hum_res <= 16'h0000;
      tmp_res <= 16'h0000;
      conv_active <= 1'b0;
      sys_idle <= 1'b0;
      cal_reload <= 1'b0;
    end
    else
    begin
      cal_reload <= 1'b0;
      case (sstate)
        hsc_pkg::SY_POWER_UP:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == hsc_pkg::CNT_W'(hsc_pkg::POWER_UP_CYC - 1))
          begin
            cnt <= '0;
            done_tgl <= ~done_tgl;
            sys_idle <= 1'b1;
            sstate <= hsc_pkg::SY_IDLE;
          end
        end
        hsc_pkg::SY_IDLE:
        begin
          if (req_ev)
          begin
            sys_idle <= 1'b0;
            cnt <= '0;
            if (req_reset)
            begin
              cal_reload <= 1'b1;
              sstate <= hsc_pkg::SY_SOFT_RESET;
            end
            else
            begin
              conv_active <= 1'b1;
              sstate <= hsc_pkg::SY_CONVERT;
            end
          end
        end
        hsc_pkg::SY_CONVERT:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == hsc_pkg::CNT_W'(CONV_CYCLES - 1))
          begin
            cnt <= '0;
            hum_res <= humidity_raw;
            tmp_res <= temperature_raw;
            done_tgl <= ~done_tgl;
            conv_active <= 1'b0;
            sys_idle <= 1'b1;
            sstate <= hsc_pkg::SY_IDLE;
          end
        end
        hsc_pkg::SY_SOFT_RESET:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == hsc_pkg::CNT_W'(hsc_pkg::SOFT_RESET_CYC - 1))
          begin
            cnt <= '0;
            done_tgl <= ~done_tgl;
            sys_idle <= 1'b1;
            sstate <= hsc_pkg::SY_IDLE;
          end
        end
        default:
          sstate <= hsc_pkg::SY_IDLE;
      endcase
    end
  end

endmodule : hsc_command_port

/* verilog/hsc_crc8.sv */
// eight-bit checksum over one 16-bit word, result registered
// assumes the word is held stable; checksum valid one edge after it settles
module hsc_crc8
(
  input wire logic clk,
  input wire logic nrst,
  hsc_crc_if.calc port
);

  logic [7:0] next_crc;

  always_comb
  begin
    logic fb;
    fb = 1'b0;
    next_crc = hsc_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      fb = next_crc[7] ^ port.word[i];
      next_crc = {next_crc[6:0], 1'b0} ^ (fb ? hsc_pkg::CRC_POLY : 8'h00);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      port.crc <= 8'h00;
    else
      port.crc <= next_crc;
  end

endmodule : hsc_crc8

/* verilog/hsc_crc_if.sv */
// carries one data word to a checksum unit and its checksum back
// assumes both ends sit in the same clock domain
interface hsc_crc_if;
  logic [15:0] word;
  logic [7:0] crc;

  modport calc
  (
    input word,
    output crc
  );

  modport user
  (
    output word,
    input crc
  );
endinterface : hsc_crc_if

/* verilog/hsc_pkg.sv */
// constants shared by the humidity sensor command port and its checksum helper
// assumes a 10 MHz system clock; link side oversamples the two-wire pins
package hsc_pkg;

  // bus address and command codes
  localparam logic [6:0] ADDR = 7'h70;
  localparam logic [15:0] CMD_STRETCH_TEMP = 16'h7ca2;
  localparam logic [15:0] CMD_STRETCH_HUM = 16'h5c24;
  localparam logic [15:0] CMD_FREE_TEMP = 16'h7866;
  localparam logic [15:0] CMD_FREE_HUM = 16'h58e0;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h805d;

  // checksum: msb first, no reflection, no final inversion
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // result readout: two words, each with its checksum
  localparam logic [2:0] LAST_BYTE = 3'h5;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // timing, longest figures so the device is ready no later than promised
  localparam int CLK_MHZ = 10;
  localparam int POWER_UP_US = 239;
  localparam int SOFT_RESET_US = 230;
  localparam int CONVERSION_US = 14400;
  localparam int POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
  localparam int SOFT_RESET_CYC = SOFT_RESET_US * CLK_MHZ;
  localparam int CONVERSION_CYC = CONVERSION_US * CLK_MHZ;
  localparam int CNT_W = 18;

  typedef enum logic [1:0] {
    SY_POWER_UP,
    SY_IDLE,
    SY_CONVERT,
    SY_SOFT_RESET
  } hsc_sys_state_type;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_HEADER,
    LK_CMD,
    LK_ACK,
    LK_STRETCH,
    LK_SEND,
    LK_MACK,
    LK_IGNORE
  } hsc_link_state_type;

endpackage : hsc_pkg
